// ==== core/epiu_defs.vh ====
// register offsets, field positions, reset values, sense codes and bus responses for the external pin interrupt unit
`ifndef EPIU_DEFS_VH
`define EPIU_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define EPIU_OFF_SENSE   4'h0
`define EPIU_OFF_STATUS  4'h4
`define EPIU_OFF_ENABLE  4'h8
`define EPIU_OFF_FLAGS   4'hC
`define EPIU_ADDR_W      4

// ****************************************
// field positions
// ****************************************
`define EPIU_A_SENSE_LO  0
`define EPIU_A_SENSE_HI  1
`define EPIU_B_SENSE_LO  2
`define EPIU_B_SENSE_HI  3
`define EPIU_C_EDGE_SEL  6
`define EPIU_GIE_BIT     0
`define EPIU_C_BIT       5
`define EPIU_A_BIT       6
`define EPIU_B_BIT       7

// ****************************************
// reset values and sense codes
// ****************************************
`define EPIU_RST_BYTE    8'h00
`define EPIU_SENSE_LOW   2'h0
`define EPIU_SENSE_ANY   2'h1
`define EPIU_SENSE_FALL  2'h2
`define EPIU_SENSE_RISE  2'h3

// ****************************************
// bus responses
// ****************************************
`define EPIU_RESP_OKAY   2'h0
`define EPIU_RESP_SLVERR 2'h2

`endif

// ==== core/epiu_sync_edge.v ====
// two-stage synchroniser with edge and level sensing for one clocked pin
`timescale 1ns/1ns
module epiu_sync_edge (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // pin and sense selection
  input  wire       pinIn,
  input  wire [1:0] sense,
  // result
  output reg        edgeHit,
  output wire       lowLevel
);
`include "epiu_defs.vh"

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // ****************************************
  // synchroniser and edge compare
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign lowLevel = ~sync_q;

  always @* begin
    case (sense)
      `EPIU_SENSE_ANY:  edgeHit = sync_q ^ prev_q;
      `EPIU_SENSE_FALL: edgeHit = prev_q & ~sync_q;
      `EPIU_SENSE_RISE: edgeHit = ~prev_q & sync_q;
      default:          edgeHit = 1'b0;
    endcase
  end
endmodule

// ==== core/epiu_top.v ====
// external pin interrupt unit: three lines, sense control, flags, enables, AXI4-Lite registers
//
// Contract
// - line B requests need global and own enable
// - line B sense: low, change, fall, rise
// - lines A/B sampled before edge detection
// - line A sense in low control bits
// - line C edge only, bit selects polarity
// - line C edges captured without clock
// - enable bits 7 B, 6 A, 5 C
// - pin activity detected even when driven output
// - each line has its own vector
// - flag bits 7 B, 6 A, 5 C
// - flag, enable, global enable vector the core
// - flags clear on service or written one
// - level-sensed lines keep flag cleared
// - line C buffer-off change may set flag
// - enabled low level requests while pin low
// - A/B edges clocked, level and C clockless; here A/B level is taken through the clocked synchroniser
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module epiu_top (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // external lines, read from the pad input so driven pins still trigger
  input  wire        extLineA,
  input  wire        extLineB,
  input  wire        extLineC,
  input  wire        lineCBufferOff,
  // processor side
  input  wire        globalIrqEnable,
  input  wire [2:0]  serviceAck,
  output reg  [2:0]  vectorReq,
  output reg         irqOut,
  output reg         wakeReq,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
`include "epiu_defs.vh"

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0]  senseCtl_q;
  reg  [7:0]  statusCtl_q;
  reg  [7:0]  enable_q;
  reg  [7:0]  flags_q;
  reg  [7:0]  flags_d;
  reg  [3:0]  awAddr_q;
  reg         awHeld_q;
  reg  [7:0]  wData_q;
  reg         wByte0_q;
  reg         wHeld_q;
  reg         gieMeta_q;
  reg         gieSync_q;
  reg  [2:0]  ackMeta_q;
  reg  [2:0]  ackSync_q;
  reg         cClrMeta_q;
  reg         cClrSync_q;
  reg         cEvMeta_q;
  reg         cEvSync_q;
  reg         cEvPrev_q;
  reg         cBufMeta_q;
  reg         cBufSync_q;
  reg         cBufPrev_q;
  reg         cTog_q;
  reg         cClrTog_q;

  wire [1:0]  senseA = senseCtl_q[`EPIU_A_SENSE_HI:`EPIU_A_SENSE_LO];
  wire [1:0]  senseB = senseCtl_q[`EPIU_B_SENSE_HI:`EPIU_B_SENSE_LO];
  wire        levelA = (senseA == `EPIU_SENSE_LOW);
  wire        levelB = (senseB == `EPIU_SENSE_LOW);
  wire        edgeA;
  wire        edgeB;
  wire        lowA;
  wire        lowB;

  // ****************************************
  // lines A and B: clocked edge detection
  // ****************************************
  epiu_sync_edge uLineA (
    .clk      (clk),
    .nrst     (nrst),
    .pinIn    (extLineA),
    .sense    (senseA),
    .edgeHit  (edgeA),
    .lowLevel (lowA)
  );

  epiu_sync_edge uLineB (
    .clk      (clk),
    .nrst     (nrst),
    .pinIn    (extLineB),
    .sense    (senseB),
    .edgeHit  (edgeB),
    .lowLevel (lowB)
  );

  // ****************************************
  // line C: clockless edge capture
  // ****************************************
  // the pad itself clocks a toggle so a pulse is kept with the system clock stopped;
  // polarity is picked by inverting the pin, which is why a polarity change can fire
  wire cPin = (extLineC ^ ~statusCtl_q[`EPIU_C_EDGE_SEL]) & ~lineCBufferOff;

  always @(posedge cPin or negedge nrst) begin
    if (!nrst) begin
      cTog_q <= 1'b0;
    end else begin
      cTog_q <= ~cTog_q;
    end
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  // one chain per source, two for the C toggle; nothing but its second stage reads a first stage
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gieMeta_q <= 1'b0;
      gieSync_q <= 1'b0;
    end else begin
      gieMeta_q <= globalIrqEnable;
      gieSync_q <= gieMeta_q;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ackMeta_q <= 3'h0;
      ackSync_q <= 3'h0;
    end else begin
      ackMeta_q <= serviceAck;
      ackSync_q <= ackMeta_q;
    end
  end

  // the toggle crosses as a level, so any change of its synchronised copy is one event
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cEvMeta_q <= 1'b0;
      cEvSync_q <= 1'b0;
      cEvPrev_q <= 1'b0;
    end else begin
      cEvMeta_q <= cTog_q;
      cEvSync_q <= cEvMeta_q;
      cEvPrev_q <= cEvSync_q;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cBufMeta_q <= 1'b0;
      cBufSync_q <= 1'b0;
      cBufPrev_q <= 1'b0;
    end else begin
      cBufMeta_q <= lineCBufferOff;
      cBufSync_q <= cBufMeta_q;
      cBufPrev_q <= cBufSync_q;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cClrMeta_q <= 1'b0;
      cClrSync_q <= 1'b0;
    end else begin
      cClrMeta_q <= cTog_q;
      cClrSync_q <= cClrMeta_q;
    end
  end

  wire cEvent  = cEvSync_q ^ cEvPrev_q;
  wire cBufEdg = cBufSync_q & ~cBufPrev_q & ~enable_q[`EPIU_C_BIT];

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  wire awTake   = s_axi_awvalid & s_axi_awready;
  wire wTake    = s_axi_wvalid & s_axi_wready;
  wire wrFire   = awHeld_q & wHeld_q & ~s_axi_bvalid;
  wire wrFlags  = wrFire & wByte0_q & (awAddr_q == `EPIU_OFF_FLAGS);
  wire [7:0] wByte = wData_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EPIU_RESP_OKAY;
      awAddr_q      <= 4'h0;
      awHeld_q      <= 1'b0;
      wData_q       <= 8'h00;
      wByte0_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      senseCtl_q    <= `EPIU_RST_BYTE;
      statusCtl_q   <= `EPIU_RST_BYTE;
      enable_q      <= `EPIU_RST_BYTE;
    end else begin
      if (awTake) begin
        awAddr_q      <= s_axi_awaddr;
        awHeld_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wTake) begin
        wData_q      <= s_axi_wdata[7:0];
        wByte0_q     <= s_axi_wstrb[0];
        wHeld_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `EPIU_RESP_OKAY;
        case (awAddr_q)
          `EPIU_OFF_SENSE:  if (wByte0_q) senseCtl_q <= {4'h0, wByte[3:0]};
          `EPIU_OFF_STATUS: if (wByte0_q) statusCtl_q[`EPIU_C_EDGE_SEL] <= wByte[`EPIU_C_EDGE_SEL];
          `EPIU_OFF_ENABLE: if (wByte0_q) enable_q <= {wByte[7:5], 5'h00};
          `EPIU_OFF_FLAGS:  ;
          default:          s_axi_bresp <= `EPIU_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `EPIU_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `EPIU_RESP_OKAY;
        case (s_axi_araddr)
          `EPIU_OFF_SENSE:  s_axi_rdata <= {24'h0, senseCtl_q};
          `EPIU_OFF_STATUS: s_axi_rdata <= {24'h0, statusCtl_q};
          `EPIU_OFF_ENABLE: s_axi_rdata <= {24'h0, enable_q};
          `EPIU_OFF_FLAGS:  s_axi_rdata <= {24'h0, flags_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `EPIU_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // flags: set beats clear
  // ****************************************
  wire [7:0] setVec = {edgeB, edgeA, (cEvent | cBufEdg), 5'h00};
  wire [7:0] ackVec = {ackSync_q[1], ackSync_q[0], ackSync_q[2], 5'h00};
  wire [7:0] w1cVec = wrFlags ? {wByte[7:5], 5'h00} : 8'h00;

  always @* begin
    flags_d = (flags_q & ~(w1cVec | ackVec)) | setVec;
    if (levelA) begin
      flags_d[`EPIU_A_BIT] = 1'b0;
    end
    if (levelB) begin
      flags_d[`EPIU_B_BIT] = 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= `EPIU_RST_BYTE;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ****************************************
  // requests to the core
  // ****************************************
  // level requests follow the synchronised pin directly, so a held low keeps requesting
  wire reqA = levelA ? lowA : flags_q[`EPIU_A_BIT];
  wire reqB = levelB ? lowB : flags_q[`EPIU_B_BIT];
  wire reqC = flags_q[`EPIU_C_BIT];
  wire [2:0] live = {reqC & enable_q[`EPIU_C_BIT],
                     reqB & enable_q[`EPIU_B_BIT],
                     reqA & enable_q[`EPIU_A_BIT]} & {3{gieSync_q}};

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vectorReq <= 3'h0;
      irqOut    <= 1'b0;
    end else begin
      vectorReq <= live;
      irqOut    <= |live;
    end
  end

  // ****************************************
  // wake request
  // ****************************************
  // sources for waking: synchronised level on A/B and the clockless C toggle
  wire wakeA = levelA & lowA & enable_q[`EPIU_A_BIT];
  wire wakeB = levelB & lowB & enable_q[`EPIU_B_BIT];
  wire wakeC = cClrSync_q ^ cClrTog_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wakeReq <= 1'b0;
    end else begin
      wakeReq <= wakeA | wakeB | wakeC;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cClrTog_q <= 1'b0;
    end else begin
      cClrTog_q <= cClrSync_q;
    end
  end
endmodule

// ==== tb/epiu_pin_src.sv ====
// external signal sources driving the three interrupt lines
`timescale 1ns/1ns
module epiu_pin_src (
  // line levels
  output logic lineA,
  output logic lineB,
  output logic lineC
);
  initial begin
    lineA = 1'b1;
    lineB = 1'b1;
    lineC = 1'b1;
  end
  // pins move off the clock grid and hold each level until told otherwise
  task automatic setLine(input int idx, input logic v);
    #1;
    case (idx)
      0: lineA = v;
      1: lineB = v;
      default: lineC = v;
    endcase
  endtask
endmodule

// ==== tb/epiu_top_sva.sv ====
// port checks for the external pin interrupt unit
`timescale 1ns/1ns
`include "epiu_defs.vh"
module epiu_top_sva (
  // clock and reset
  input logic        clk,
  input logic        nrst,
  // processor side
  input logic        globalIrqEnable,
  input logic [2:0]  vectorReq,
  input logic        irqOut,
  // register bus
  input logic        s_axi_awready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [3:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while busy");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == `EPIU_RESP_SLVERR) else $error("unmapped read not refused");
  irq_or_a: assert property (irqOut == |vectorReq)
    else $error("irq out differs from requests");
  gie_off_a: assert property (!globalIrqEnable [*5] |-> vectorReq == 3'h0)
    else $error("request without global enable");
endmodule
bind epiu_top epiu_top_sva i_sva (.clk(clk), .nrst(nrst), .globalIrqEnable(globalIrqEnable),
  .vectorReq(vectorReq), .irqOut(irqOut), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== tb/test_external_pin_interrupt_unit.sv ====
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ns
`include "epiu_defs.vh"
module test_external_pin_interrupt_unit;
  logic        clk, nrst, lnA, lnB, lnC, bufOff, gie, hit;
  logic        irq, wake, awV, awR, wV, wR, bV, bR, arV, arR, rV, rR;
  logic [2:0]  ack, vec, ev;
  logic [3:0]  awA, arA;
  logic [31:0] wD, rD, d;
  logic [1:0]  bRsp, rRsp, r;
  logic [15:0] lfsr;
  int          fails, checksDone;
  epiu_pin_src i_src (.lineA(lnA), .lineB(lnB), .lineC(lnC));
  epiu_top i_dut (.clk(clk), .nrst(nrst), .extLineA(lnA), .extLineB(lnB), .extLineC(lnC),
    .lineCBufferOff(bufOff), .globalIrqEnable(gie), .serviceAck(ack), .vectorReq(vec), .irqOut(irq),
    .wakeReq(wake), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRsp), .s_axi_bvalid(bV),
    .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
    .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rR));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] nextRnd(input logic [15:0] s);
    nextRnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // the top 16 data bits are random: the unit must ignore them
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    lfsr = nextRnd(lfsr);
    awA <= a;
    wD <= {lfsr, 8'h00, v};
    awV <= 1'b1;
    wV <= 1'b1;
    bR <= 1'b1;
    do begin
      @(posedge clk);
      if (awR) awV <= 1'b0;
      if (wR) wV <= 1'b0;
    end while (bV !== 1'b1);
    r = bRsp;
    bR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    arA <= a;
    arV <= 1'b1;
    rR <= 1'b1;
    do begin
      @(posedge clk);
      if (arR) arV <= 1'b0;
    end while (rV !== 1'b1);
    d = rD;
    r = rRsp;
    rR <= 1'b0;
  endtask
  task automatic end_sim();
    if (fails == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    end_sim();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {nrst, bufOff, gie, awV, wV, bR, arV, rR} = 8'h00;
    {ack, awA, arA, wD} = 43'h0;
    lfsr = 16'hFA01;
    fails = 0;
    checksDone = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4));
      chk("reset value", d, 32'h0);
    end
    rd(4'h2);
    chk("unmapped rresp", r, `EPIU_RESP_SLVERR);
    wr(4'h6, 8'hFF);
    chk("unmapped bresp", r, `EPIU_RESP_SLVERR);
    wr(4'h8, 8'hE0);
    rd(4'h8);
    chk("enable", d, 32'hE0);
    gie <= 1'b1;
    for (int l = 0; l < 2; l++) begin
      wr(4'h8, 8'h40 << l);
      for (int c = 0; c < 4; c++) begin
        wr(4'h0, 8'(c << (2 * l)));
        for (int v = 0; v < 2; v++) begin
          hit = (c == 1) || (c == 2 && v == 0) || (c == 3 && v == 1);
          i_src.setLine(l, v);
          tick(8);
          rd(4'hC);
          chk("flag", d[6 + l], hit);
          ev = 3'((c == 0) ? !v : hit) << l;
          chk("vector", vec, ev);
          chk("irq", irq, |ev);
          chk("wake", wake, (c == 0 && v == 0));
          if (hit) begin
            gie <= 1'b0;
            tick(6);
            chk("masked", vec, 3'h0);
            gie <= 1'b1;
          end
          if (v == 1) begin
            ack <= 3'h1 << l;
            tick(6);
            ack <= 3'h0;
          end else begin
            wr(4'hC, 8'h40 << l);
          end
          tick(6);
          chk("cleared", vec, 3'(c == 0 && v == 0) << l);
        end
      end
    end
    for (int s = 0; s < 2; s++) begin
      wr(4'h8, 8'h00);
      wr(4'h4, 8'(s << 6));
      tick(6);
      wr(4'hC, 8'h20);
      wr(4'h8, 8'h20);
      for (int v = 0; v < 2; v++) begin
        hit = (v == s);
        i_src.setLine(2, v);
        tick(8);
        rd(4'hC);
        chk("c flag", d[5], hit);
        chk("c vector", vec, 3'(hit) << 2);
        ack <= 3'h4;
        tick(6);
        ack <= 3'h0;
        tick(4);
        rd(4'hC);
        chk("c acked", d[5], 1'b0);
      end
    end
    wr(4'h8, 8'h00);
    bufOff <= 1'b1;
    tick(8);
    rd(4'hC);
    chk("sleep flag", d[5], 1'b1);
    end_sim();
  end
endmodule
